/* pkg/isa_pkg.sv */
// constants for the serial stereo audio port: framing, bit-clock divider and buffer
// assumes a single 200 MHz core clock and 16-bit left/right sample words
package isa_pkg;
	// core clock rate in kHz (5 ns period)
	localparam int CLOCK_KHZ = 200000;
	// frame rate produced as master, in kHz
	localparam int FRAME_RATE_KHZ = 48;
	// bit periods per frame in the two master framings
	localparam logic [5:0] FRAME_BITS_SHORT = 6'h20;
	localparam logic [5:0] FRAME_BITS_LONG = 6'h32;
	// channel word length and the index of its last bit
	localparam int WORD_BITS = 16;
	localparam logic [3:0] WORD_LAST = 4'hF;
	// fastest bit clock accepted as slave, in kHz
	localparam int SLAVE_MAX_SCK_KHZ = 3072;
	// least slave bit-clock period in core cycles, rounded up
	localparam int SLAVE_MIN_PERIOD_CYC = (CLOCK_KHZ + SLAVE_MAX_SCK_KHZ - 1) / SLAVE_MAX_SCK_KHZ;
	// least share of a period for either bit-clock phase, in percent
	localparam int DUTY_MIN_PCT = 35;
	// divider settings (toggle rate = clock * num / den) for 1.536 MHz and 2.400 MHz
	localparam logic [15:0] DIV_NUM_SHORT = 16'h0060;
	localparam logic [15:0] DIV_DEN_SHORT = 16'h186A;
	localparam logic [15:0] DIV_NUM_LONG = 16'h0003;
	localparam logic [15:0] DIV_DEN_LONG = 16'h007D;
	// sample buffer: one stereo pair per entry, two entries
	localparam int BUF_WIDTH = 2 * WORD_BITS;
	// reset values of the pin drivers
	localparam logic SCK_RESET = 1'b0;
	localparam logic WS_RESET = 1'b0;
	localparam logic OE_N_RESET = 1'b1;

	// half-frame length, where word select flips
	function automatic logic [5:0] isa_half(input logic long_frame);
		return long_frame ? (FRAME_BITS_LONG >> 1) : (FRAME_BITS_SHORT >> 1);
	endfunction

	// last bit index of a frame
	function automatic logic [5:0] isa_last(input logic long_frame);
		return long_frame ? (FRAME_BITS_LONG - 6'h01) : (FRAME_BITS_SHORT - 6'h01);
	endfunction
endpackage

/* logic/isa_pair_buffer.sv */
// two-entry buffer holding stereo sample pairs between the feeder and the serialiser
// assumes feeder and serialiser share the core clock; enable low freezes it
module isa_pair_buffer
	import isa_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic enable,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [BUF_WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [BUF_WIDTH-1:0] out_data
);
	// whole buffer state
	typedef struct packed {
		logic [1:0][BUF_WIDTH-1:0] mem; // storage
		logic wr; // write slot
		logic rd; // read slot
		logic [1:0] count; // words held
		logic ready; // room for a word
	} isa_buf_type;

	isa_buf_type st;
	isa_buf_type next_st;
	logic push; // word accepted
	logic pop; // word drained

	// push/pop bookkeeping; ready drops when both entries are full
	always_comb begin
		next_st = st;
		push = enable && in_valid && st.ready;
		pop = enable && out_ready && (st.count != 2'h0);
		if (push) begin
			next_st.mem[st.wr] = in_data;
			next_st.wr = !st.wr;
		end
		if (pop) begin
			next_st.rd = !st.rd;
		end
		next_st.count = 2'(st.count + {1'b0, push} - {1'b0, pop});
		next_st.ready = (next_st.count != 2'h2);
	end

	// state register
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			st <= '0;
			st.ready <= 1'b1;
		end else if (enable) begin
			st <= next_st;
		end
	end

	assign in_ready = st.ready;
	assign out_valid = (st.count != 2'h0);
	assign out_data = st.mem[st.rd];
endmodule // isa_pair_buffer

/* logic/isa_audio_port.sv */
// serial stereo audio port: master or slave bit clock, 16-bit words, data on falling edges
// assumes pins arrive asynchronous to clock; the pad ring builds wires from the oe_n pins
// Overview of operation
// - master drives clock and select, slave receives
// - serial data output is always driven
// - 16-bit words, MSB in slot MSB position
// - MSB one bit after select change, falling edges
// - left while select low, right while high
// - master frames: 48 kHz, 32 or 50 bits
// - master clock from fractional N/M divider
// - slave accepts any clock up to 3.072 MHz
// - master clock phases each at least 35 percent
module isa_audio_port
	import isa_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic enable,
	input wire logic master_mode,
	input wire logic long_frame,
	input wire logic [15:0] div_num,
	input wire logic [15:0] div_den,
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic [15:0] tx_left,
	input wire logic [15:0] tx_right,
	input wire logic sck_in,
	output logic sck_out,
	output logic sck_oe_n,
	input wire logic ws_in,
	output logic ws_out,
	output logic ws_oe_n,
	output logic sdo
);
	// whole port state
	typedef struct packed {
		logic [2:0] sck_sync; // bit clock synchroniser and edge history
		logic [1:0] ws_sync; // word select synchroniser
		logic [15:0] acc; // divider phase accumulator
		logic sck; // generated bit clock
		logic ws; // generated word select
		logic oe_n; // clock/select drivers off
		logic sdo; // serial data
		logic [5:0] cnt; // bit index in frame
		logic ws_rise; // select seen at last rising edge
		logic ws_prev; // select of the bit period before
		logic [15:0] sh; // word bits still to send
		logic [3:0] left; // bits still to send
		logic [15:0] right_hold; // right word of current pair
	} isa_state_type;

	isa_state_type st;
	isa_state_type next_st;
	logic [16:0] sum; // accumulator plus step
	logic tick; // bit-clock half-period elapsed
	logic fall; // falling bit-clock edge
	logic rise; // rising bit-clock edge
	logic cur; // select during the period that ends
	logic load; // first bit of a new word
	logic take; // pull a pair from the buffer
	logic [15:0] word; // word being loaded
	logic [5:0] next_cnt; // following bit index
	logic buf_valid; // buffer holds a pair
	logic [BUF_WIDTH-1:0] buf_data; // oldest pair, left high

	// sample pairs queue here so a late feeder costs no word
	isa_pair_buffer u_buf (
		.clock(clock),
		.rst_n(rst_n),
		.enable(enable),
		.in_valid(tx_valid),
		.in_ready(tx_ready),
		.in_data({tx_left, tx_right}),
		.out_valid(buf_valid),
		.out_ready(take),
		.out_data(buf_data)
	);

	// edge generation, framing and serialising
	always_comb begin
		next_st = st;
		sum = {1'b0, st.acc} + {1'b0, div_num};
		tick = 1'b0;
		fall = 1'b0;
		rise = 1'b0;
		cur = 1'b0;
		load = 1'b0;
		take = 1'b0;
		word = 16'h0000;
		next_cnt = st.cnt;
		if (enable) begin
			next_st.sck_sync = {st.sck_sync[1:0], sck_in};
			next_st.ws_sync = {st.ws_sync[0], ws_in};
			next_st.oe_n = !master_mode;
			if (master_mode) begin
				if (div_den == 16'h0000) begin
					next_st.acc = 16'h0000;
				end else if (sum >= {1'b0, div_den}) begin
					tick = 1'b1;
					next_st.acc = 16'(sum - {1'b0, div_den});
				end else begin
					next_st.acc = sum[15:0];
				end
				fall = tick && st.sck;
				rise = tick && !st.sck;
				if (tick) begin
					next_st.sck = !st.sck;
				end
			end else begin
				next_st.acc = 16'h0000;
				next_st.sck = SCK_RESET;
				rise = st.sck_sync[1] && !st.sck_sync[2];
				fall = !st.sck_sync[1] && st.sck_sync[2];
				if (rise) begin
					next_st.ws_rise = st.ws_sync[1];
				end
			end
			if (fall) begin
				cur = master_mode ? st.ws : st.ws_rise;
				load = (cur != st.ws_prev);
				next_st.ws_prev = cur;
				if (master_mode) begin
					// frame of 32 or 50 bits
					next_cnt = (st.cnt >= isa_last(long_frame)) ? 6'h00 : 6'(st.cnt + 6'h01);
					next_st.cnt = next_cnt;
					// low half left, high half right
					next_st.ws = (next_cnt >= isa_half(long_frame));
				end
				if (load) begin
					// left word opens a new pair
					if (!cur) begin
						take = buf_valid;
						word = buf_valid ? buf_data[BUF_WIDTH-1:WORD_BITS] : 16'h0000;
						next_st.right_hold = buf_valid ? buf_data[WORD_BITS-1:0] : 16'h0000;
					end else begin
						word = st.right_hold;
					end
					next_st.sdo = word[15];
					next_st.sh = {word[14:0], 1'b0};
					next_st.left = WORD_LAST;
				end else if (st.left != 4'h0) begin
					next_st.sdo = st.sh[15];
					next_st.sh = {st.sh[14:0], 1'b0};
					next_st.left = 4'(st.left - 4'h1);
				end else begin
					next_st.sdo = 1'b0;
				end
			end
		end
	end

	// state register, frozen while enable is low
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			st <= '0;
			st.sck <= SCK_RESET;
			st.ws <= WS_RESET;
			st.oe_n <= OE_N_RESET;
		end else if (enable) begin
			st <= next_st;
		end
	end

	// data pin has no enable, always driven
	assign sdo = st.sdo;
	assign sck_out = st.sck;
	assign ws_out = st.ws;
	assign sck_oe_n = st.oe_n;
	assign ws_oe_n = st.oe_n;

	// phase-length helper for the duty check
	logic [11:0] hi_len; // cycles of current/last high phase
	logic [11:0] lo_len; // cycles of current/last low phase
	always_ff @(posedge clock) begin
		if (!rst_n || !master_mode) begin
			hi_len <= 12'h000;
			lo_len <= 12'h000;
		end else if (enable) begin
			if (st.sck) begin
				hi_len <= 12'(hi_len + 12'h001);
				if (!next_st.sck) begin
					lo_len <= 12'h000;
				end
			end else begin
				lo_len <= 12'(lo_len + 12'h001);
				if (next_st.sck) begin
					hi_len <= 12'h000;
				end
			end
		end
	end

	// a falling edge that starts a word
	sequence load_edge_s;
		enable && fall && load;
	endsequence

	// a falling edge past the last bit
	sequence pad_edge_s;
		enable && fall && !load && st.left == 4'h0;
	endsequence

	// the first edge after reset release still shows the reset drivers
	pin_dir_a: assert property (@(posedge clock) disable iff (!rst_n)
		$past(rst_n) && $past(enable) && $past(master_mode) |-> !sck_oe_n && !ws_oe_n)
		else $error("clock/select not driven in master mode");
	slave_dir_a: assert property (@(posedge clock) disable iff (!rst_n)
		$past(rst_n) && $past(enable) && !$past(master_mode) |-> sck_oe_n && ws_oe_n)
		else $error("clock/select driven in slave mode");
	msb_load_a: assert property (@(posedge clock) disable iff (!rst_n)
		load_edge_s |=> sdo == $past(word[15]) && st.left == WORD_LAST)
		else $error("word MSB not placed at word start");
	left_low_a: assert property (@(posedge clock) disable iff (!rst_n)
		load_edge_s ##0 (!cur && buf_valid) |=> sdo == $past(buf_data[BUF_WIDTH-1]))
		else $error("left word not sent in low select half");
	zero_pad_a: assert property (@(posedge clock) disable iff (!rst_n)
		pad_edge_s |=> !sdo)
		else $error("slot not padded with zeros");
	frame_wrap_a: assert property (@(posedge clock) disable iff (!rst_n)
		enable && master_mode && fall && st.cnt == isa_last(long_frame) |=> st.cnt == 6'h00 && !ws_out)
		else $error("master frame length wrong");
	ws_half_a: assert property (@(posedge clock) disable iff (!rst_n)
		enable && master_mode && fall && next_cnt == isa_half(long_frame) |=> ws_out ##1 $stable(ws_out))
		else $error("select does not flip at half frame");
	acc_bound_a: assert property (@(posedge clock) disable iff (!rst_n)
		enable && master_mode && div_den != 16'h0000 && div_num < div_den && st.acc < div_den
		|=> st.acc < $past(div_den))
		else $error("divider accumulator overran denominator");
	duty_high_a: assert property (@(posedge clock) disable iff (!rst_n)
		enable && master_mode && st.sck && !next_st.sck && lo_len != 12'h000
		|-> (int'(hi_len) + 1) * 100 >= DUTY_MIN_PCT * (int'(hi_len) + 1 + int'(lo_len)))
		else $error("bit clock high phase too short");
	duty_low_a: assert property (@(posedge clock) disable iff (!rst_n)
		enable && master_mode && !st.sck && next_st.sck && hi_len != 12'h000
		|-> (int'(lo_len) + 1) * 100 >= DUTY_MIN_PCT * (int'(lo_len) + 1 + int'(hi_len)))
		else $error("bit clock low phase too short");
endmodule // isa_audio_port

/* sim/isa_codec_model.sv */
// far-side model: a codec that receives the port's serial stream and, in slave mode, makes the clocks
// assumes sck and ws arrive as resolved wire levels built by the bench from the port's enables
module isa_codec_model
	import isa_pkg::*;
#(
	parameter int SCK_LOW = 42, // slave clock low phase in core cycles
	parameter int SCK_HIGH = 24 // slave clock high phase in core cycles
)
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic run,
	input wire logic sck,
	input wire logic ws,
	input wire logic sdo,
	output logic drv_sck,
	output logic drv_ws,
	output logic [31:0] pair,
	output int pairs,
	output int frame_bits,
	output int tail_ones
);
	timeunit 1ns;
	timeprecision 100ps;
	int phase = 0; // position within one slave clock period
	int nbit = 0; // bit index within a slave frame
	int cnt = 31; // bits since the last select change, 31 = idle
	int rises = 0; // rising edges since the right slot began
	logic ws_prev = 1'b0; // select seen at the previous rising edge
	logic [15:0] shift = 16'h0000; // received bits, newest at the bottom
	initial begin
		drv_sck = 1'b0;
		drv_ws = 1'b0;
		pair = 32'h00000000;
		pairs = 0;
		frame_bits = 0;
		tail_ones = 0;
	end
	// slave clock source
	// fixed phases, stands still while run is low; select moves on falling edges
	always @(posedge clock) begin
		if (run) begin
			if (phase == SCK_LOW + SCK_HIGH - 1) begin
				phase <= 0;
				drv_sck <= 1'b0;
				nbit <= (nbit + 1) % 32;
				drv_ws <= ((nbit + 1) % 32) >= 16;
			end else begin
				phase <= phase + 1;
				// high phase begins
				if (phase + 1 == SCK_LOW) begin
					drv_sck <= 1'b1;
				end
			end
		end
	end
	// capture on rising edges
	// word starts one bit after a select change; left while low, right while high
	always @(posedge sck or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 31;
			// a stale left half must not pair with the first fresh right word
			pair <= 32'h00000000;
		end else begin
			shift <= {shift[14:0], sdo};
			ws_prev <= ws;
			rises <= rises + 1;
			if (ws !== ws_prev) begin
				cnt <= 0;
				// a right slot start closes one frame
				if (ws) begin
					frame_bits <= rises;
					rises <= 1;
				end
			end else if (cnt < 31) begin
				cnt <= cnt + 1;
			end
			// last of 16 bits arrived
			// in a 32-bit frame the last bit lands in the next slot, so the channel is the previous select
			if (cnt == 15) begin
				if (ws_prev) begin
					pair[15:0] <= {shift[14:0], sdo};
					pairs <= pairs + 1;
				end else begin
					pair[31:16] <= {shift[14:0], sdo};
				end
			end
			if (ws === ws_prev && cnt >= 16 && cnt < 31 && sdo !== 1'b0) begin
				tail_ones <= tail_ones + 1;
			end
		end
	end
endmodule // isa_codec_model

/* sim/isa_audio_port_test.sv */
// bench for the serial stereo audio port: slave and both master framings against a codec model
// assumes the package divider settings give 48 kHz frames from the 200 MHz clock
module isa_audio_port_test
	import isa_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock;
	logic rst_n = 1'b0;
	logic enable = 1'b1;
	logic master_mode = 1'b0;
	logic long_frame = 1'b0;
	logic [15:0] div_num = 16'h0000;
	logic [15:0] div_den = 16'h0001;
	logic tx_valid = 1'b0;
	logic tx_ready;
	logic [15:0] tx_left = 16'h0000;
	logic [15:0] tx_right = 16'h0000;
	logic sck_out, sck_oe_n, ws_out, ws_oe_n, sdo;
	logic run = 1'b0; // far side makes the slave clock
	logic drv_sck, drv_ws;
	logic [31:0] pair;
	int pairs, frame_bits, tail_ones;
	int num_errors = 0;
	int n_checks = 0;
	int seen = 0; // pairs already collected
	int sdo_bad = 0; // data changes outside a low clock
	logic sdo_q = 1'b0;
	logic [31:0] got_q[$]; // received non-zero pairs
	// resolved wires: the port drives while its enable is low
	wire logic sck_w = !sck_oe_n ? sck_out : drv_sck;
	wire logic ws_w = !ws_oe_n ? ws_out : drv_ws;
	isa_audio_port i_isa_audio_port (.clock(clock), .rst_n(rst_n), .enable(enable), .master_mode(master_mode),
		.long_frame(long_frame), .div_num(div_num), .div_den(div_den), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.tx_left(tx_left), .tx_right(tx_right), .sck_in(sck_w), .sck_out(sck_out), .sck_oe_n(sck_oe_n),
		.ws_in(ws_w), .ws_out(ws_out), .ws_oe_n(ws_oe_n), .sdo(sdo));
	isa_codec_model i_isa_codec_model (.clock(clock), .rst_n(rst_n), .run(run), .sck(sck_w), .ws(ws_w), .sdo(sdo),
		.drv_sck(drv_sck), .drv_ws(drv_ws), .pair(pair), .pairs(pairs), .frame_bits(frame_bits), .tail_ones(tail_ones));
	// clock source, 5 ns period
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	// collect finished pairs, drop underrun zeros; data moves only while the clock is low
	always @(posedge clock) begin
		if (pairs != seen) begin
			seen = pairs;
			if (pair !== 32'h00000000) got_q.push_back(pair);
		end
		if (rst_n === 1'b1 && sdo !== sdo_q && sck_w !== 1'b0) sdo_bad++;
		sdo_q = sdo;
	end
	// value comparison
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	// range comparison
	task automatic check_in(input int v, input int lo, input int hi, input string what);
		n_checks++;
		if (v < lo || v > hi) begin
			num_errors++;
			$display("ERROR %0t %s value %0d outside %0d..%0d", $time, what, v, lo, hi);
		end
	endtask
	// reset with a configuration, then look at the reset levels
	task automatic start(input logic m, input logic lf, input logic [15:0] num, input logic [15:0] den);
		rst_n <= 1'b0;
		master_mode <= m;
		long_frame <= lf;
		div_num <= num;
		div_den <= den;
		run <= 1'b0;
		repeat (16) @(posedge clock);
		check({27'h0, sdo, sck_out, ws_out, sck_oe_n, ws_oe_n}, 32'h3, "reset pins");
		check({31'h0, tx_ready}, 32'h1, "reset ready");
		rst_n <= 1'b1;
		repeat (2) @(posedge clock);
		got_q.delete();
	endtask
	// offer pairs back to back, each held until taken
	task automatic push_all(input logic [31:0] d[$]);
		int n;
		foreach (d[i]) begin
			tx_valid <= 1'b1;
			{tx_left, tx_right} <= d[i];
			n = 0;
			do begin
				@(posedge clock);
				n++;
			end while (tx_ready !== 1'b1 && n < 30000);
		end
		tx_valid <= 1'b0;
	endtask
	// wait for the pairs at the far side and compare them in order
	task automatic expect_pairs(input logic [31:0] d[$]);
		int n;
		n = 0;
		while (got_q.size() < d.size() && n < 30000) begin
			@(posedge clock);
			n++;
		end
		foreach (d[i]) check(got_q.size() > i ? got_q[i] : 32'h0, d[i], "pair");
		check_in(sdo_bad, 0, 0, "data edge");
	endtask
	// slave: stalled far side fills the buffer, then the fastest legal clock drains it
	task automatic t_slave;
		start(1'b0, 1'b0, DIV_NUM_SHORT, DIV_DEN_SHORT);
		check({30'h0, sck_oe_n, ws_oe_n}, 32'h3, "slave enables");
		push_all({32'h80017FFE, 32'hA5C30F1E});
		repeat (20) @(posedge clock);
		check({31'h0, tx_ready}, 32'h0, "buffer full");
		run <= 1'b1;
		push_all({32'h1234FFFF});
		expect_pairs({32'h80017FFE, 32'hA5C30F1E, 32'h1234FFFF});
		$display("slave test done");
	endtask
	// master: frame length, frame period, clock phases and slot tail
	task automatic t_master(input logic lf);
		int c, hi, lo;
		logic [3:0] pins; // pin levels when the enable drops
		start(1'b1, lf, lf ? DIV_NUM_LONG : DIV_NUM_SHORT, lf ? DIV_DEN_LONG : DIV_DEN_SHORT);
		check({30'h0, sck_oe_n, ws_oe_n}, 32'h0, "master enables");
		push_all({32'hC0010003, 32'h7FFF8000, 32'h5A5AA5A5});
		expect_pairs({32'hC0010003, 32'h7FFF8000, 32'h5A5AA5A5});
		check(frame_bits, lf ? FRAME_BITS_LONG : FRAME_BITS_SHORT, "frame bits");
		check(tail_ones, 0, "slot tail");
		c = 0;
		while (ws_w !== 1'b0 && c < 9000) begin @(posedge clock); c++; end
		while (ws_w !== 1'b1 && c < 9000) begin @(posedge clock); c++; end
		c = 0;
		do begin @(posedge clock); c++; end while (ws_w !== 1'b0 && c < 9000);
		do begin @(posedge clock); c++; end while (ws_w !== 1'b1 && c < 9000);
		check_in(c, CLOCK_KHZ / FRAME_RATE_KHZ, CLOCK_KHZ / FRAME_RATE_KHZ + 2, "frame period");
		hi = 0;
		lo = 0;
		while (sck_w !== 1'b1) @(posedge clock);
		while (sck_w === 1'b1) begin @(posedge clock); hi++; end
		while (sck_w !== 1'b1) begin @(posedge clock); lo++; end
		check_in(hi * 100, DUTY_MIN_PCT * (hi + lo), 100000, "high phase");
		check_in(lo * 100, DUTY_MIN_PCT * (hi + lo), 100000, "low phase");
		// clock enable low freezes divider, pins and buffer; a running clock would toggle within 100 cycles
		enable <= 1'b0;
		@(posedge clock);
		pins = {sck_out, ws_out, sdo, tx_ready};
		repeat (100) @(posedge clock);
		check({28'h0, sck_out, ws_out, sdo, tx_ready}, {28'h0, pins}, "frozen pins");
		enable <= 1'b1;
		$display("master test done, long framing %0d", lf);
	endtask
	// counts, verdict and end of run
	task automatic complete_run;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// watchdog, well beyond the expected 55000 cycles
	initial begin
		repeat (95000) @(posedge clock);
		num_errors++;
		$display("ERROR %0t run did not finish", $time);
		complete_run();
	end
	// main sequence
	initial begin
		@(posedge clock);
		t_slave();
		t_master(1'b0);
		t_master(1'b1);
		complete_run();
	end
endmodule // isa_audio_port_test
